// *** design/pwm_timer_top.sv ***
// pwm block top: axi4-lite registers, 8-bit time base, two channels
// assumes one 100 MHz clock taken as the oscillator, sync reset
`timescale 1ns/10ps
module pwm_timer_top #(
  parameter int unsigned ADDR_WIDTH = 8
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // axi4-lite write address
  input wire logic [ADDR_WIDTH-1:0] awaddr_i,
  input wire logic awvalid_i,
  output logic awready_o,
  // axi4-lite write data
  input wire logic [31:0] wdata_i,
  input wire logic [3:0] wstrb_i,
  input wire logic wvalid_i,
  output logic wready_o,
  // axi4-lite write response
  output logic [1:0] bresp_o,
  output logic bvalid_o,
  input wire logic bready_i,
  // axi4-lite read address
  input wire logic [ADDR_WIDTH-1:0] araddr_i,
  input wire logic arvalid_i,
  output logic arready_o,
  // axi4-lite read data
  output logic [31:0] rdata_o,
  output logic [1:0] rresp_o,
  output logic rvalid_o,
  input wire logic rready_i,
  // modulated pins and shutdown pin
  output logic [pwm_pkg::NUM_CH-1:0] pin_o,
  output logic [pwm_pkg::NUM_CH-1:0] pin_oe_o,
  input wire logic shutdown_i,
  // postscaled period events for other users
  output logic period_event_o
);
  localparam int AW = ADDR_WIDTH;

  // the map needs six address bits
  if (ADDR_WIDTH < 6) begin : g_bad_width
    $error("ADDR_WIDTH too small for the register map");
  end

  // bus state
  pwm_pkg::wr_state_type wr_state_reg;
  pwm_pkg::wr_state_type wr_state_next;
  logic [AW-1:0] wr_addr_reg;
  logic [7:0] wr_data_reg;
  logic wr_strb_reg;
  logic [1:0] bresp_reg;
  logic rvalid_reg;
  logic [7:0] rdata_reg;
  logic [1:0] rresp_reg;
  // software registers
  logic [7:0] tmr_reg;
  logic [7:0] period_reg;
  pwm_pkg::timer_ctrl_type tctrl_reg;
  logic [1:0] dir_reg;
  logic [7:0] upper_reg [pwm_pkg::NUM_CH];
  pwm_pkg::chan_ctrl_type ctrl_reg [pwm_pkg::NUM_CH];
  // time base state
  logic [1:0] q_reg;
  logic [3:0] pre_reg;
  logic [3:0] post_reg;
  logic event_reg;
  logic sd_meta_reg;
  logic sd_sync_reg;
  // decode and time base wires
  logic aw_fire;
  logic w_fire;
  logic ar_fire;
  logic wr_commit;
  logic [AW-1:0] wa;
  logic [7:0] wd;
  logic we;
  logic we_timer;
  logic we_period;
  logic we_tctrl;
  logic we_dir;
  logic wr_hit;
  logic rd_timer;
  logic rd_period;
  logic rd_tctrl;
  logic rd_dir;
  logic rd_hit;
  logic [7:0] rd_byte;
  logic [pwm_pkg::NUM_CH:0] wr_ch_acc;
  logic [pwm_pkg::NUM_CH:0] rd_ch_acc;
  logic [7:0] rd_val_acc [pwm_pkg::NUM_CH+1];
  logic icyc_end;
  logic pre_last;
  logic tick;
  logic period_end;
  logic [1:0] ext;
  pwm_pkg::tbase_type tbase;

  // handshakes: one write and one read in flight
  assign aw_fire = awvalid_i && awready_o;
  assign w_fire = wvalid_i && wready_o;
  assign ar_fire = arvalid_i && arready_o;
  assign awready_o = (wr_state_reg == pwm_pkg::W_IDLE) || (wr_state_reg == pwm_pkg::W_DATA);
  assign wready_o = (wr_state_reg == pwm_pkg::W_IDLE) || (wr_state_reg == pwm_pkg::W_ADDR);
  assign bvalid_o = (wr_state_reg == pwm_pkg::W_RESP);
  assign bresp_o = bresp_reg;
  assign arready_o = !rvalid_reg;
  assign rvalid_o = rvalid_reg;
  assign rdata_o = {24'h000000, rdata_reg};
  assign rresp_o = rresp_reg;

  // write channel sequencing, address and data in either order
  always_comb begin
    wr_state_next = wr_state_reg;
    case (wr_state_reg)
      pwm_pkg::W_IDLE: begin
        if (aw_fire && w_fire) begin
          wr_state_next = pwm_pkg::W_RESP;
        end else if (aw_fire) begin
          wr_state_next = pwm_pkg::W_ADDR;
        end else if (w_fire) begin
          wr_state_next = pwm_pkg::W_DATA;
        end
      end
      pwm_pkg::W_ADDR: begin
        if (w_fire) begin
          wr_state_next = pwm_pkg::W_RESP;
        end
      end
      pwm_pkg::W_DATA: begin
        if (aw_fire) begin
          wr_state_next = pwm_pkg::W_RESP;
        end
      end
      pwm_pkg::W_RESP: begin
        if (bready_i) begin
          wr_state_next = pwm_pkg::W_IDLE;
        end
      end
      default: begin
        wr_state_next = pwm_pkg::W_IDLE;
      end
    endcase
  end

  // the write lands on the edge that completes address and data
  assign wr_commit = (wr_state_reg != pwm_pkg::W_RESP) && (wr_state_next == pwm_pkg::W_RESP);
  assign wa = aw_fire ? awaddr_i : wr_addr_reg;
  assign wd = w_fire ? wdata_i[7:0] : wr_data_reg;
  // registers are one byte wide, so only lane 0 matters
  assign we = wr_commit && (w_fire ? wstrb_i[0] : wr_strb_reg);
  // period set only through its register
  assign we_period = we && (wa == AW'(pwm_pkg::ADDR_PERIOD));
  assign we_timer = we && (wa == AW'(pwm_pkg::ADDR_TIMER));
  assign we_tctrl = we && (wa == AW'(pwm_pkg::ADDR_TCTRL));
  assign we_dir = we && (wa == AW'(pwm_pkg::ADDR_DIR));
  assign wr_hit = (wa == AW'(pwm_pkg::ADDR_PERIOD)) || (wa == AW'(pwm_pkg::ADDR_TIMER))
    || (wa == AW'(pwm_pkg::ADDR_TCTRL)) || (wa == AW'(pwm_pkg::ADDR_DIR))
    || wr_ch_acc[pwm_pkg::NUM_CH];

  // read decode as a priority chain
  assign rd_timer = (araddr_i == AW'(pwm_pkg::ADDR_TIMER));
  assign rd_period = (araddr_i == AW'(pwm_pkg::ADDR_PERIOD));
  assign rd_tctrl = (araddr_i == AW'(pwm_pkg::ADDR_TCTRL));
  assign rd_dir = (araddr_i == AW'(pwm_pkg::ADDR_DIR));
  assign rd_hit = rd_timer || rd_period || rd_tctrl || rd_dir || rd_ch_acc[pwm_pkg::NUM_CH];
  assign rd_byte = rd_timer ? tmr_reg
    : rd_period ? period_reg
    : rd_tctrl ? tctrl_reg
    : rd_dir ? {6'h00, dir_reg}
    : rd_val_acc[pwm_pkg::NUM_CH];

  // bus registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wr_state_reg <= pwm_pkg::W_IDLE;
      wr_addr_reg <= '0;
      wr_data_reg <= 8'h00;
      wr_strb_reg <= 1'b0;
      bresp_reg <= pwm_pkg::RESP_OKAY;
    end else begin
      wr_state_reg <= wr_state_next;
      if (aw_fire) begin
        wr_addr_reg <= awaddr_i;
      end
      if (w_fire) begin
        wr_data_reg <= wdata_i[7:0];
        wr_strb_reg <= wstrb_i[0];
      end
      if (wr_commit) begin
        bresp_reg <= wr_hit ? pwm_pkg::RESP_OKAY : pwm_pkg::RESP_SLVERR;
      end
    end
  end

  // read answer one cycle after the address; unmapped reads zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= 8'h00;
      rresp_reg <= pwm_pkg::RESP_OKAY;
    end else if (ar_fire) begin
      rvalid_reg <= 1'b1;
      rdata_reg <= rd_hit ? rd_byte : 8'h00;
      rresp_reg <= rd_hit ? pwm_pkg::RESP_OKAY : pwm_pkg::RESP_SLVERR;
    end else if (rready_i) begin
      rvalid_reg <= 1'b0;
    end
  end

  // timer configuration registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      period_reg <= pwm_pkg::PERIOD_RESET;
      tctrl_reg <= '0;
      dir_reg <= pwm_pkg::DIR_RESET;
    end else begin
      if (we_period) begin
        period_reg <= wd;
      end
      if (we_tctrl) begin
        tctrl_reg <= pwm_pkg::timer_ctrl_type'({1'b0, wd[6:0]});
      end
      if (we_dir) begin
        dir_reg <= wd[1:0];
      end
    end
  end

  // instruction cycle of four clocks, then prescale
  assign icyc_end = (q_reg == pwm_pkg::Q_LAST);
  // only ratios one, four and sixteen exist
  assign pre_last = (tctrl_reg.prescale == pwm_pkg::PRE_DIV1) ? 1'b1
    : (tctrl_reg.prescale == pwm_pkg::PRE_DIV4) ? (pre_reg[1:0] == pwm_pkg::PRE_TOP4)
    : (pre_reg == pwm_pkg::PRE_TOP16);
  assign tick = tctrl_reg.run && icyc_end && pre_last;
  // match is acted on at the next increment
  assign period_end = tick && (tmr_reg == period_reg);
  // low compare bits give tosc times prescale steps
  assign ext = (tctrl_reg.prescale == pwm_pkg::PRE_DIV1) ? q_reg
    : (tctrl_reg.prescale == pwm_pkg::PRE_DIV4) ? pre_reg[1:0]
    : pre_reg[3:2];
  assign tbase = '{period_start: period_end, count: tmr_reg, ext: ext};

  // phase, prescaler and timer; a timer write restarts the prescaler
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q_reg <= 2'h0;
      pre_reg <= 4'h0;
      tmr_reg <= 8'h00;
    end else begin
      q_reg <= q_reg + 2'h1;
      if (we_timer) begin
        pre_reg <= 4'h0;
        tmr_reg <= wd;
      end else if (tctrl_reg.run && icyc_end) begin
        pre_reg <= pre_last ? 4'h0 : pre_reg + 4'h1;
        if (period_end) begin
          // clear to start a new period
          tmr_reg <= 8'h00;
        end else if (tick) begin
          tmr_reg <= tmr_reg + 8'h01;
        end
      end
    end
  end

  // postscaler only divides the event output
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      post_reg <= 4'h0;
      event_reg <= 1'b0;
    end else begin
      event_reg <= period_end && (post_reg == tctrl_reg.postscale);
      if (period_end) begin
        post_reg <= (post_reg == tctrl_reg.postscale) ? 4'h0 : post_reg + 4'h1;
      end
    end
  end
  assign period_event_o = event_reg;

  // shutdown pin crosses in through two flops
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sd_meta_reg <= 1'b0;
      sd_sync_reg <= 1'b0;
    end else begin
      sd_meta_reg <= shutdown_i;
      sd_sync_reg <= sd_meta_reg;
    end
  end

  assign wr_ch_acc[0] = 1'b0;
  assign rd_ch_acc[0] = 1'b0;
  assign rd_val_acc[0] = 8'h00;

  // one register group and channel per output pin
  for (genvar i = 0; i < pwm_pkg::NUM_CH; i++) begin : g_ch
    localparam logic [7:0] BASE = 8'(pwm_pkg::ADDR_CH_BASE + i * pwm_pkg::CH_STRIDE);
    // channel two has no enhanced bits
    localparam logic [7:0] CMASK = (i == 0) ? 8'hFF : pwm_pkg::CH2_CTRL_MASK;
    logic w_up;
    logic w_sh;
    logic w_ct;
    logic r_up;
    logic r_sh;
    logic r_ct;
    logic [7:0] shadow;
    logic [7:0] r_val;

    assign w_up = (wa == AW'(BASE + pwm_pkg::OFS_UPPER));
    assign w_sh = (wa == AW'(BASE + pwm_pkg::OFS_SHADOW));
    assign w_ct = (wa == AW'(BASE + pwm_pkg::OFS_CTRL));
    assign r_up = (araddr_i == AW'(BASE + pwm_pkg::OFS_UPPER));
    assign r_sh = (araddr_i == AW'(BASE + pwm_pkg::OFS_SHADOW));
    assign r_ct = (araddr_i == AW'(BASE + pwm_pkg::OFS_CTRL));
    assign r_val = r_up ? upper_reg[i] : r_sh ? shadow : r_ct ? ctrl_reg[i] : 8'h00;
    assign wr_ch_acc[i+1] = wr_ch_acc[i] || w_up || w_sh || w_ct;
    assign rd_ch_acc[i+1] = rd_ch_acc[i] || r_up || r_sh || r_ct;
    assign rd_val_acc[i+1] = rd_val_acc[i] | r_val;

    // duty bits writable at any time
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        upper_reg[i] <= 8'h00;
        ctrl_reg[i] <= '0;
      end else begin
        if (we && w_up) begin
          upper_reg[i] <= wd;
        end
        if (we && w_ct) begin
          // clearing channel two control turns it off
          ctrl_reg[i] <= pwm_pkg::chan_ctrl_type'(wd & CMASK);
        end
      end
    end

    pwm_channel #(
      .HAS_SHUTDOWN(i == 0)
    ) u_channel (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .ctrl_i(ctrl_reg[i]),
      .upper_i(upper_reg[i]),
      .shadow_wr_i(we && w_sh),
      .shadow_data_i(wd),
      .tbase_i(tbase),
      .shutdown_i(sd_sync_reg),
      .shadow_o(shadow),
      .pin_o(pin_o[i])
    );
    // direction bit low means the pin drives
    assign pin_oe_o[i] = !dir_reg[i];
  end

  // cycles between ticks, checked while the setup holds
  logic [6:0] gap_reg;
  logic gap_ok_reg;
  logic [6:0] gap_want;
  assign gap_want = (tctrl_reg.prescale == pwm_pkg::PRE_DIV1) ? pwm_pkg::GAP_DIV1
    : (tctrl_reg.prescale == pwm_pkg::PRE_DIV4) ? pwm_pkg::GAP_DIV4 : pwm_pkg::GAP_DIV16;
  always_ff @(posedge clk_i) begin
    if (rst_i || we_tctrl || we_timer || !tctrl_reg.run) begin
      gap_reg <= 7'h00;
      gap_ok_reg <= 1'b0;
    end else begin
      gap_reg <= tick ? 7'h00 : gap_reg + 7'h01;
      gap_ok_reg <= gap_ok_reg || tick;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  timer_wrap_a: assert property (period_end && !we_timer |=> tmr_reg == 8'h00) else $error("timer not cleared after period match");
  tick_gap_a: assert property (tick && gap_ok_reg |-> gap_reg == gap_want) else $error("timer tick spacing wrong");
  tick_phase_a: assert property (tick |-> tctrl_reg.run && q_reg == pwm_pkg::Q_LAST) else $error("tick outside run or phase");
  event_src_a: assert property (period_event_o |-> $past(period_end)) else $error("event without period match");
  bus_resp_a: assert property (wr_commit |=> bvalid_o) else $error("write answer late");
  period_c: cover property (period_end);
  event_c: cover property (period_event_o);
  both_pins_c: cover property (pin_o[0] && pin_o[1]);
endmodule : pwm_timer_top

// *** design/pwm_pkg.sv ***
// pwm block package: register map, field layouts, carrier types
// assumes byte offsets on a 32-bit axi4-lite bus, one word per register
// What this block does
// - period length comes from period register
// - timer clears after matching period register
// - pin set each period unless duty zero
// - duty upper copied to shadow at period start
// - postscaler never touches pwm period or pin
// - duty is upper byte plus control bits 5:4
// - high time is duty times tosc times prescale
// - duty writes take effect next period
// - shadow register read-only in pwm mode
// - shadow plus hidden latch double-buffer duty
// - pin cleared when duty equals extended count
// - duty beyond period keeps pin high
// - prescaler ratios are one, four, sixteen
// - only channel one honours shutdown
// - mode upper bits 11 select pwm
// - mode 0000 turns channel off, resets
// - clearing channel two control drives pin low
package pwm_pkg;
  // register byte offsets
  localparam logic [7:0] ADDR_TIMER = 8'h00;
  localparam logic [7:0] ADDR_PERIOD = 8'h04;
  localparam logic [7:0] ADDR_TCTRL = 8'h08;
  localparam logic [7:0] ADDR_CH_BASE = 8'h0C;
  localparam logic [7:0] CH_STRIDE = 8'h0C;
  localparam logic [7:0] OFS_UPPER = 8'h00;
  localparam logic [7:0] OFS_SHADOW = 8'h04;
  localparam logic [7:0] OFS_CTRL = 8'h08;
  localparam logic [7:0] ADDR_DIR = 8'h24;
  localparam int unsigned NUM_CH = 2;
  // reset values and implemented bits
  localparam logic [7:0] PERIOD_RESET = 8'hFF;
  localparam logic [1:0] DIR_RESET = 2'h3;
  localparam logic [7:0] CH2_CTRL_MASK = 8'h3F;
  // instruction cycle phase
  localparam logic [1:0] Q_LAST = 2'h3;
  // prescale codes and counter tops
  localparam logic [1:0] PRE_DIV1 = 2'h0;
  localparam logic [1:0] PRE_DIV4 = 2'h1;
  localparam logic [1:0] PRE_TOP4 = 2'h3;
  localparam logic [3:0] PRE_TOP16 = 4'hF;
  // clock cycles between ticks, minus one
  localparam logic [6:0] GAP_DIV1 = 7'h03;
  localparam logic [6:0] GAP_DIV4 = 7'h0F;
  localparam logic [6:0] GAP_DIV16 = 7'h3F;
  // channel modes
  localparam logic [3:0] MODE_OFF = 4'h0;
  localparam logic [1:0] MODE_PWM = 2'h3;
  // bus answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // timer control layout, top bit unimplemented
  typedef struct packed {
    logic unused;
    logic [3:0] postscale;
    logic run;
    logic [1:0] prescale;
  } timer_ctrl_type;
  // channel control layout
  typedef struct packed {
    logic [1:0] output_cfg;
    logic [1:0] duty_low;
    logic [3:0] mode;
  } chan_ctrl_type;
  // time base shared by the channels
  typedef struct packed {
    logic period_start;
    logic [7:0] count;
    logic [1:0] ext;
  } tbase_type;
  // write channel states
  typedef enum logic [3:0] {
    W_IDLE = 4'h1,
    W_ADDR = 4'h2,
    W_DATA = 4'h4,
    W_RESP = 4'h8
  } wr_state_type;
endpackage : pwm_pkg

// *** design/pwm_channel.sv ***
// one pwm channel: duty double buffer, compare and pin latch
// assumes a time base on the same clock and a synchronised shutdown
`timescale 1ns/10ps
module pwm_channel #(
  parameter bit HAS_SHUTDOWN = 1'b0
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // software side
  input wire pwm_pkg::chan_ctrl_type ctrl_i,
  input wire logic [7:0] upper_i,
  input wire logic shadow_wr_i,
  input wire logic [7:0] shadow_data_i,
  // time base and shutdown
  input wire pwm_pkg::tbase_type tbase_i,
  input wire logic shutdown_i,
  // results
  output logic [7:0] shadow_o,
  output logic pin_o
);
  logic [7:0] shadow_reg;
  logic [1:0] latch_reg;
  logic pin_reg;
  logic start_dly_reg;
  logic pwm_mode;
  logic mode_off;
  logic sd_force;
  logic match;
  logic [9:0] duty_new;

  assign pwm_mode = (ctrl_i.mode[3:2] == pwm_pkg::MODE_PWM);
  assign mode_off = (ctrl_i.mode == pwm_pkg::MODE_OFF);
  assign sd_force = HAS_SHUTDOWN && shutdown_i;
  // upper byte then two low bits
  assign duty_new = {upper_i, ctrl_i.duty_low};
  // compare with extended count; no match past period
  assign match = ({shadow_reg, latch_reg} == {tbase_i.count, tbase_i.ext});
  assign shadow_o = shadow_reg;
  assign pin_o = pin_reg;

  always_ff @(posedge clk_i) begin
    if (rst_i || mode_off) begin
      shadow_reg <= 8'h00;
      latch_reg <= 2'h0;
    end else if (pwm_mode && tbase_i.period_start) begin
      shadow_reg <= upper_i;
      latch_reg <= ctrl_i.duty_low;
    end else if (!pwm_mode && shadow_wr_i) begin
      shadow_reg <= shadow_data_i;
    end
  end

  // boundary seen one clock late: the clear also lands one edge after its match,
  // so the high time is exactly duty steps; the pin lags the boundary by one tosc
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      start_dly_reg <= 1'b0;
    end else begin
      start_dly_reg <= tbase_i.period_start;
    end
  end

  // pin latch; the delayed start wins over a stale match
  always_ff @(posedge clk_i) begin
    if (rst_i || !pwm_mode || sd_force) begin
      // any non-pwm mode or shut down drives low
      pin_reg <= 1'b0;
    end else if (start_dly_reg) begin
      // set unless the freshly buffered duty is zero
      pin_reg <= ({shadow_reg, latch_reg} != 10'h000);
    end else if (match) begin
      pin_reg <= 1'b0;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  duty_load_a: assert property (pwm_mode && tbase_i.period_start |=> {shadow_reg, latch_reg} == $past(duty_new)) else $error("duty not loaded at period start");
  duty_hold_a: assert property (pwm_mode && !tbase_i.period_start |=> $stable({shadow_reg, latch_reg})) else $error("duty buffer changed mid period");
  pin_set_a: assert property (pwm_mode && !sd_force && start_dly_reg && {shadow_reg, latch_reg} != 10'h000 |=> pin_reg) else $error("pin not set at period start");
  zero_duty_a: assert property (pwm_mode && tbase_i.period_start && duty_new == 10'h000 |=> ##1 !pin_reg) else $error("pin set with zero duty");
  pin_clear_a: assert property (match && !start_dly_reg |=> !pin_reg) else $error("pin high after duty match");
  off_reset_a: assert property (mode_off |=> !pin_reg && shadow_reg == 8'h00) else $error("off mode left state");
  shutdown_low_a: assert property (sd_force ##1 sd_force |-> !pin_reg) else $error("pin high in shutdown");
  pin_fall_c: cover property (pin_reg ##1 !pin_reg);
endmodule : pwm_channel

// *** sim/pwm_load.sv ***
// load model on one modulated pin: measures high time and period
// assumes the pin is sampled on the block clock, no reset of its own
`timescale 1ns/10ps
module pwm_load (
  // sampling clock
  input wire logic clk_i,
  // observed pin and its enable
  input wire logic pin_i,
  input wire logic oe_i,
  // last figures in clock cycles
  output logic [15:0] high_o,
  output logic [15:0] period_o
);
  logic pin_reg = 1'b0;
  logic [15:0] hcnt_reg = 16'h0000;
  logic [15:0] pcnt_reg = 16'h0000;
  // an undriven pin never counts as a rise
  always_ff @(posedge clk_i) begin
    pin_reg <= pin_i && oe_i;
    if (pin_i && oe_i && !pin_reg) begin
      period_o <= pcnt_reg;
      pcnt_reg <= 16'h0001;
      hcnt_reg <= 16'h0001;
    end else begin
      pcnt_reg <= pcnt_reg + 16'h0001;
      hcnt_reg <= hcnt_reg + {15'h0000, pin_i};
    end
    if (pin_reg && !pin_i) high_o <= hcnt_reg;
  end
endmodule : pwm_load

// *** sim/tb.sv ***
// pwm block bench: axi4-lite master tasks, pin scenarios, verdict
// assumes pwm_pkg and one load model per modulated pin
`timescale 1ns/10ps
module tb;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] awaddr_i = 8'h00;
  logic [7:0] araddr_i = 8'h00;
  logic [31:0] wdata_i = 32'h0;
  logic [3:0] wstrb_i = 4'h0;
  logic awvalid_i = 1'b0;
  logic wvalid_i = 1'b0;
  logic bready_i = 1'b0;
  logic arvalid_i = 1'b0;
  logic rready_i = 1'b0;
  logic shutdown_i = 1'b0;
  logic awready_o, wready_o, bvalid_o, arready_o, rvalid_o, event_o;
  logic [1:0] bresp_o, rresp_o, pin_o, pin_oe_o;
  logic [31:0] rdata_o;
  logic [15:0] high0, high1, per0, per1;
  int miscompares = 0;
  int checks = 0;
  localparam logic [7:0] CH1 = pwm_pkg::ADDR_CH_BASE;
  localparam logic [7:0] CH2 = pwm_pkg::ADDR_CH_BASE + pwm_pkg::CH_STRIDE;
  localparam logic [7:0] SH = pwm_pkg::OFS_SHADOW;
  localparam logic [7:0] CT = pwm_pkg::OFS_CTRL;

  // device and one load per pin
  pwm_timer_top #(.ADDR_WIDTH(8)) i_dut (
    .clk_i(clk_i), .rst_i(rst_i), .awaddr_i(awaddr_i), .awvalid_i(awvalid_i),
    .awready_o(awready_o), .wdata_i(wdata_i), .wstrb_i(wstrb_i), .wvalid_i(wvalid_i),
    .wready_o(wready_o), .bresp_o(bresp_o), .bvalid_o(bvalid_o), .bready_i(bready_i),
    .araddr_i(araddr_i), .arvalid_i(arvalid_i), .arready_o(arready_o), .rdata_o(rdata_o),
    .rresp_o(rresp_o), .rvalid_o(rvalid_o), .rready_i(rready_i), .pin_o(pin_o),
    .pin_oe_o(pin_oe_o), .shutdown_i(shutdown_i), .period_event_o(event_o));
  pwm_load i_load0 (.clk_i(clk_i), .pin_i(pin_o[0]), .oe_i(pin_oe_o[0]), .high_o(high0),
    .period_o(per0));
  pwm_load i_load1 (.clk_i(clk_i), .pin_i(pin_o[1]), .oe_i(pin_oe_o[1]), .high_o(high1),
    .period_o(per1));

  // 100 MHz clock
  always #5 clk_i = ~clk_i;

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // each half released at its own handshake edge; the spare edge keeps bready single-driven
  task automatic bus_write(input logic [7:0] a, input logic [7:0] d, input logic [3:0] s,
                           output logic [1:0] resp);
    int n;
    n = 0;
    awaddr_i <= a;
    wdata_i <= {24'h000000, d};
    wstrb_i <= s;
    awvalid_i <= 1'b1;
    wvalid_i <= 1'b1;
    bready_i <= 1'b1;
    do begin
      @(posedge clk_i);
      n++;
      if (awvalid_i && awready_o) awvalid_i <= 1'b0;
      if (wvalid_i && wready_o) wvalid_i <= 1'b0;
    end while (!bvalid_o && n < 100);
    resp = bresp_o;
    bready_i <= 1'b0;
    @(posedge clk_i);
  endtask : bus_write

  task automatic bus_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
    int n;
    n = 0;
    araddr_i <= a;
    arvalid_i <= 1'b1;
    rready_i <= 1'b1;
    do begin
      @(posedge clk_i);
      n++;
      if (arvalid_i && arready_o) arvalid_i <= 1'b0;
    end while (!rvalid_o && n < 100);
    d = rdata_o;
    resp = rresp_o;
    rready_i <= 1'b0;
    @(posedge clk_i);
  endtask : bus_read

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [1:0] r;
    bus_write(a, d, 4'h1, r);
  endtask : wr

  task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0] r;
    bus_read(a, d, r);
    check(what, d, exp);
  endtask : rdc

  // high cycles of one pin over two periods at prescale one
  task automatic win(input string what, input int ch, input int exp);
    int hi;
    hi = 0;
    repeat (32) begin
      @(posedge clk_i);
      if (pin_o[ch] === 1'b1) hi++;
    end
    check(what, hi, exp);
  endtask : win

  task automatic test_reset;
    logic [31:0] d;
    logic [1:0] r;
    rdc("period reset", pwm_pkg::ADDR_PERIOD, 32'hFF);
    rdc("timer ctrl reset", pwm_pkg::ADDR_TCTRL, 32'h0);
    rdc("direction reset", pwm_pkg::ADDR_DIR, 32'h3);
    bus_write(pwm_pkg::ADDR_PERIOD, 8'h33, 4'h0, r);
    rdc("period unstrobed", pwm_pkg::ADDR_PERIOD, 32'hFF);
    bus_write(8'h28, 8'h11, 4'h1, r);
    check("write unmapped", {30'h0, r}, {30'h0, pwm_pkg::RESP_SLVERR});
    bus_read(8'h28, d, r);
    check("read unmapped", {30'h0, r}, {30'h0, pwm_pkg::RESP_SLVERR});
  endtask : test_reset

  // period, duty, pin, timer, then mode
  task automatic setup;
    wr(pwm_pkg::ADDR_PERIOD, 8'h03);
    wr(CH1, 8'h01);
    wr(CH2, 8'h02);
    wr(CH2 + CT, 8'h20);
    wr(pwm_pkg::ADDR_DIR, 8'h00);
    wr(pwm_pkg::ADDR_TCTRL, 8'h0C);
    wr(CH1 + CT, 8'h0C);
    wr(CH2 + CT, 8'h2F);
    check("pin enables", {30'h0, pin_oe_o}, 32'h3);
  endtask : setup

  task automatic test_prescale;
    for (int p = 0; p < 4; p++) begin
      int k;
      k = (p >= 2) ? 4 : 2 * p;
      wr(pwm_pkg::ADDR_TCTRL, 8'h0C | 8'(p));
      repeat (48 << k) @(posedge clk_i);
      check("period ch1", per0, 32'h10 << k);
      check("high ch1", high0, 32'h4 << k);
      check("high ch2", high1, 32'hA << k);
      check("period ch2", per1, 32'h10 << k);
    end
    wr(pwm_pkg::ADDR_TCTRL, 8'h0C);
    repeat (48) @(posedge clk_i);
  endtask : test_prescale

  task automatic test_shutdown;
    shutdown_i <= 1'b1;
    repeat (20) @(posedge clk_i);
    win("ch1 shut", 0, 0);
    win("ch2 unshut", 1, 20);
    shutdown_i <= 1'b0;
    repeat (48) @(posedge clk_i);
    win("ch1 resumed", 0, 8);
  endtask : test_shutdown

  // write just after a period start so no boundary falls before the read
  task automatic test_buffer;
    @(posedge pin_o[0]);
    @(posedge clk_i);
    wr(CH1, 8'h04);
    rdc("shadow held", CH1 + SH, 32'h1);
    repeat (48) @(posedge clk_i);
    wr(CH1 + SH, 8'h55);
    rdc("shadow copied", CH1 + SH, 32'h4);
    win("duty over period", 0, 32);
    wr(CH1, 8'h00);
    repeat (48) @(posedge clk_i);
    win("zero duty", 0, 0);
  endtask : test_buffer

  task automatic test_off;
    int ev;
    ev = 0;
    wr(CH1, 8'h01);
    wr(CH1 + CT, 8'h00);
    win("ch1 off", 0, 0);
    rdc("shadow cleared", CH1 + SH, 32'h0);
    // a non-pwm, non-off mode lets software write the shadow
    wr(CH1 + CT, 8'h08);
    wr(CH1 + SH, 8'h55);
    rdc("shadow free", CH1 + SH, 32'h55);
    win("ch2 running", 1, 20);
    wr(CH2 + CT, 8'h00);
    win("ch2 cleared", 1, 0);
    // postscale code one passes every second match: two in four periods
    repeat (64) begin
      @(posedge clk_i);
      if (event_o === 1'b1) ev++;
    end
    check("event rate", ev, 32'h2);
  endtask : test_off

  task automatic summarize;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : summarize

  // main sequence
  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    test_reset();
    setup();
    test_prescale();
    test_shutdown();
    test_buffer();
    test_off();
    summarize();
  end

  // watchdog, well beyond the few thousand cycles needed
  initial begin
    repeat (20000) @(posedge clk_i);
    miscompares++;
    summarize();
  end
endmodule : tb
